/* toc_defines.vh */
// Register map, field positions, reset values and widths of the timer output channel
`ifndef TOC_DEFINES_VH
`define TOC_DEFINES_VH

// Register byte offsets
`define TOC_ADDR_CTRL 8'h00
`define TOC_ADDR_DIV 8'h04
`define TOC_ADDR_CNT 8'h08
`define TOC_ADDR_PER 8'h0c
`define TOC_ADDR_DUTY 8'h10
`define TOC_ADDR_PER_SH 8'h14
`define TOC_ADDR_DUTY_SH 8'h18
`define TOC_ADDR_IRQ_STAT 8'h1c
`define TOC_ADDR_IRQ_CLR 8'h20
`define TOC_ADDR_IRQ_EN 8'h24
`define TOC_ADDR_STATUS 8'h28

// Control register fields
`define TOC_CTRL_EN 0
`define TOC_CTRL_SHIFT 1
`define TOC_CTRL_ONESHOT 2
`define TOC_CTRL_EXTTRIG 3
`define TOC_CTRL_RSTPER 4
`define TOC_CTRL_RELOAD_UPDATE_ENABLE_LO 5
`define TOC_CTRL_RELOAD_UPDATE_ENABLE_HI 6
`define TOC_CTRL_CLKSRC 7
`define TOC_CTRL_FXSEL_LO 8
`define TOC_CTRL_FXSEL_HI 9
`define TOC_CTRL_POL 10
`define TOC_CTRL_W 11

// Interrupt bit positions
`define TOC_IRQ_PER 0
`define TOC_IRQ_DUTY 1
`define TOC_IRQ_W 2

// Widths
`define TOC_CW 24
`define TOC_DIVW 16
`define TOC_FXW 12

// Reset values
`define TOC_CTRL_RST 11'h400
`define TOC_DIV_RST 16'h0000
`define TOC_CNT_RST 24'h000000
`define TOC_PER_RST 24'h000000
`define TOC_DUTY_RST 24'h000000
`define TOC_IRQ_RST 2'h0

// Longest shift length in bits
`define TOC_SHIFT_MAX 24'h000017

`endif

/* toc_sync.v */
// Two-stage synchroniser for one level input
`timescale 1ns/1ps
`default_nettype none
module toc_sync (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Level in and out
  input wire d,
  output reg q
);

  reg meta_q;

  // First stage feeds only the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule
`default_nettype wire

/* toc_channel.v */
// Timer output channel: PWM, one-shot and serial shift with APB registers
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "toc_defines.vh"
module toc_channel (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Trigger inputs
  input wire chain_trigger_in,
  input wire external_capture_event,
  // Channel outputs
  output reg channel_out,
  output reg period_match_trigger,
  output reg duty_match_trigger,
  output reg irq
);

  localparam PH_IDLE = 2'd0;
  localparam PH_INIT = 2'd1;
  localparam PH_PULSE = 2'd2;

  // Software state
  reg [`TOC_CTRL_W-1:0] ctrl_q;
  reg [`TOC_DIVW-1:0] divider_count_q;
  reg [`TOC_CW-1:0] period_shadow_q;
  reg [`TOC_CW-1:0] duty_shadow_q;
  reg [`TOC_IRQ_W-1:0] irq_en_q;
  reg [`TOC_IRQ_W-1:0] interrupt_notification_bits_q;
  reg [`TOC_IRQ_W-1:0] notify_d;

  // Channel state
  reg [`TOC_CW-1:0] channel_counter_q;
  reg [`TOC_CW-1:0] channel_counter_d;
  reg [`TOC_CW-1:0] period_compare_q;
  reg [`TOC_CW-1:0] period_compare_d;
  reg [`TOC_CW-1:0] duty_compare_q;
  reg [`TOC_CW-1:0] duty_compare_d;
  reg [1:0] phase_q;
  reg [1:0] phase_d;
  reg active_q;
  reg active_d;
  reg ptrig_d;
  reg dtrig_d;

  // Clock enable generation
  reg [`TOC_DIVW-1:0] div_cnt_q;
  reg [`TOC_FXW-1:0] fx_cnt_q;
  reg fx_tick;
  wire div_tick;
  wire tick;

  // Trigger capture
  wire capture_sync;
  reg capture_sync_q;
  reg capture_pend_q;
  reg chain_pend_q;
  wire capture_rise;

  // Bus decode
  reg [31:0] rd_mux;
  reg addr_ok;
  wire apb_prep;
  wire apb_wr;

  // Control fields
  wire chan_en = ctrl_q[`TOC_CTRL_EN];
  wire serial_shift_mode = ctrl_q[`TOC_CTRL_SHIFT];
  wire single_pulse_enable = ctrl_q[`TOC_CTRL_ONESHOT];
  wire external_trigger_enable = ctrl_q[`TOC_CTRL_EXTTRIG];
  wire reset_on_period_match = ctrl_q[`TOC_CTRL_RSTPER];
  wire [1:0] reload_update_enable = ctrl_q[`TOC_CTRL_RELOAD_UPDATE_ENABLE_HI:`TOC_CTRL_RELOAD_UPDATE_ENABLE_LO];
  wire clock_source_select = ctrl_q[`TOC_CTRL_CLKSRC];
  wire [1:0] fixed_select = ctrl_q[`TOC_CTRL_FXSEL_HI:`TOC_CTRL_FXSEL_LO];
  wire out_polarity = ctrl_q[`TOC_CTRL_POL];

  // Compare conditions
  wire [`TOC_CW-1:0] per_m1 = period_compare_q - 24'h000001;
  wire [`TOC_CW-1:0] duty_m1 = duty_compare_q - 24'h000001;
  wire [`TOC_CW-1:0] shift_len;
  wire per_hit;
  wire duty_hit;
  wire shift_hit;
  wire [`TOC_CW-1:0] duty_rot;
  wire start_req;
  wire capture_reset;

  // Period values 0 and 1 both mean a match on every enabled cycle; a duty of 0 never matches
  assign per_hit = (period_compare_q <= 24'h000001) | (channel_counter_q == per_m1);
  assign duty_hit = (duty_compare_q != 24'h000000) & (channel_counter_q == duty_m1);

  // Bit count clamps at the longest permitted length
  assign shift_len = (period_compare_q > `TOC_SHIFT_MAX) ? `TOC_SHIFT_MAX :
                     period_compare_q;
  assign shift_hit = channel_counter_q >= shift_len;
  assign duty_rot = {duty_compare_q[0], duty_compare_q[`TOC_CW-1:1]};

  assign apb_prep = psel & penable & ~pready;
  assign apb_wr = psel & penable & pready & pwrite;

  // Divided and fixed clock enables
  // Compare with >= so a smaller divider takes effect at once, not after a wrap
  assign div_tick = (div_cnt_q >= divider_count_q);

  always @* begin
    case (fixed_select)
      2'd0: fx_tick = 1'b1;
      2'd1: fx_tick = &fx_cnt_q[3:0];
      2'd2: fx_tick = &fx_cnt_q[7:0];
      default: fx_tick = &fx_cnt_q;
    endcase
  end

  assign tick = clock_source_select ? fx_tick : div_tick;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= `TOC_DIV_RST;
      fx_cnt_q <= 12'h000;
    end else begin
      fx_cnt_q <= fx_cnt_q + 12'h001;
      if (div_tick) begin
        div_cnt_q <= `TOC_DIV_RST;
      end else begin
        div_cnt_q <= div_cnt_q + 16'h0001;
      end
    end
  end

  // Capture goes through the synchroniser before any use
  toc_sync u_capture_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(external_capture_event),
    .q(capture_sync)
  );

  assign capture_rise = capture_sync & ~capture_sync_q;

  // Events wait for the next enable cycle; a new event beats the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_sync_q <= 1'b0;
      capture_pend_q <= 1'b0;
      chain_pend_q <= 1'b0;
    end else begin
      capture_sync_q <= capture_sync;
      capture_pend_q <= capture_rise | (capture_pend_q & ~tick);
      chain_pend_q <= chain_trigger_in | (chain_pend_q & ~tick);
    end
  end

  assign start_req = chain_pend_q | (capture_pend_q & external_trigger_enable);
  assign capture_reset = capture_pend_q & external_trigger_enable &
                         reset_on_period_match;

  // Channel next state
  always @* begin
    channel_counter_d = channel_counter_q;
    period_compare_d = period_compare_q;
    duty_compare_d = duty_compare_q;
    phase_d = phase_q;
    active_d = active_q;
    ptrig_d = 1'b0;
    dtrig_d = 1'b0;
    if (!chan_en) begin
      channel_counter_d = `TOC_CNT_RST;
      phase_d = PH_IDLE;
      active_d = 1'b0;
    end else if (serial_shift_mode) begin
      if (tick) begin
        if (shift_hit) begin
          channel_counter_d = `TOC_CNT_RST;
          ptrig_d = 1'b1;
          if (reload_update_enable != 2'b00) begin
            period_compare_d = period_shadow_q;
            duty_compare_d = duty_shadow_q;
          end else begin
            // Without reload a shift keeps the stream gap free
            active_d = duty_compare_q[0];
            duty_compare_d = duty_rot;
          end
        end else begin
          active_d = duty_compare_q[0];
          duty_compare_d = duty_rot;
          channel_counter_d = channel_counter_q + 24'h000001;
        end
      end
    end else if (single_pulse_enable) begin
      if (tick & start_req) begin
        channel_counter_d = `TOC_CNT_RST;
        phase_d = PH_INIT;
        active_d = 1'b0;
      end else if (tick & (phase_q != PH_IDLE)) begin
        ptrig_d = per_hit;
        // A period match closing the pulse brings no duty trigger
        dtrig_d = duty_hit & ((phase_q == PH_INIT) | ~per_hit);
        if (per_hit) begin
          channel_counter_d = `TOC_CNT_RST;
          if (phase_q == PH_INIT) begin
            phase_d = PH_PULSE;
            active_d = (duty_compare_q != 24'h000000);
          end else begin
            phase_d = PH_IDLE;
            active_d = 1'b0;
          end
        end else begin
          channel_counter_d = channel_counter_q + 24'h000001;
          if (duty_hit & (phase_q == PH_PULSE)) begin
            active_d = 1'b0;
          end
        end
      end
    end else begin
      if (tick) begin
        if (capture_reset) begin
          // Restart behaves like a fresh period start
          channel_counter_d = `TOC_CNT_RST;
          active_d = (duty_compare_q != 24'h000000);
        end else begin
          ptrig_d = per_hit;
          dtrig_d = duty_hit;
          if (per_hit) begin
            channel_counter_d = `TOC_CNT_RST;
            active_d = (duty_compare_q != 24'h000000);
            if (reload_update_enable[0]) begin
              period_compare_d = period_shadow_q;
            end
            if (reload_update_enable[1]) begin
              duty_compare_d = duty_shadow_q;
            end
          end else begin
            channel_counter_d = channel_counter_q + 24'h000001;
            if (duty_hit) begin
              active_d = 1'b0;
            end
          end
        end
      end
    end
    // Software writes override the channel logic
    if (apb_wr) begin
      case (paddr)
        `TOC_ADDR_CNT: begin
          channel_counter_d = pwdata[`TOC_CW-1:0];
          if (chan_en & single_pulse_enable & ~serial_shift_mode) begin
            phase_d = PH_INIT;
            active_d = 1'b0;
          end
        end
        `TOC_ADDR_PER: period_compare_d = pwdata[`TOC_CW-1:0];
        `TOC_ADDR_DUTY: duty_compare_d = pwdata[`TOC_CW-1:0];
        default: channel_counter_d = channel_counter_d;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_counter_q <= `TOC_CNT_RST;
      period_compare_q <= `TOC_PER_RST;
      duty_compare_q <= `TOC_DUTY_RST;
      phase_q <= PH_IDLE;
      active_q <= 1'b0;
      period_match_trigger <= 1'b0;
      duty_match_trigger <= 1'b0;
      channel_out <= 1'b0;
    end else begin
      channel_counter_q <= channel_counter_d;
      period_compare_q <= period_compare_d;
      duty_compare_q <= duty_compare_d;
      phase_q <= phase_d;
      active_q <= active_d;
      period_match_trigger <= ptrig_d;
      duty_match_trigger <= dtrig_d;
      // Pin follows the active state one cycle later
      channel_out <= ~(active_q ^ out_polarity);
    end
  end

  // Sticky notification; a fresh event wins over a clear
  always @* begin
    notify_d = interrupt_notification_bits_q;
    if (apb_wr & (paddr == `TOC_ADDR_IRQ_CLR)) begin
      notify_d = notify_d & ~pwdata[`TOC_IRQ_W-1:0];
    end
    notify_d = notify_d | {duty_match_trigger, period_match_trigger};
  end

  // Software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `TOC_CTRL_RST;
      divider_count_q <= `TOC_DIV_RST;
      period_shadow_q <= `TOC_PER_RST;
      duty_shadow_q <= `TOC_DUTY_RST;
      irq_en_q <= `TOC_IRQ_RST;
      interrupt_notification_bits_q <= `TOC_IRQ_RST;
      irq <= 1'b0;
    end else begin
      interrupt_notification_bits_q <= notify_d;
      irq <= |(interrupt_notification_bits_q & irq_en_q);
      if (apb_wr) begin
        case (paddr)
          `TOC_ADDR_CTRL: ctrl_q <= pwdata[`TOC_CTRL_W-1:0];
          `TOC_ADDR_DIV: divider_count_q <= pwdata[`TOC_DIVW-1:0];
          `TOC_ADDR_PER_SH: period_shadow_q <= pwdata[`TOC_CW-1:0];
          `TOC_ADDR_DUTY_SH: duty_shadow_q <= pwdata[`TOC_CW-1:0];
          `TOC_ADDR_IRQ_EN: irq_en_q <= pwdata[`TOC_IRQ_W-1:0];
          default: irq_en_q <= irq_en_q;
        endcase
      end
    end
  end

  // Read mux and address check
  always @* begin
    rd_mux = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      `TOC_ADDR_CTRL: rd_mux[`TOC_CTRL_W-1:0] = ctrl_q;
      `TOC_ADDR_DIV: rd_mux[`TOC_DIVW-1:0] = divider_count_q;
      `TOC_ADDR_CNT: rd_mux[`TOC_CW-1:0] = channel_counter_q;
      `TOC_ADDR_PER: rd_mux[`TOC_CW-1:0] = period_compare_q;
      `TOC_ADDR_DUTY: rd_mux[`TOC_CW-1:0] = duty_compare_q;
      `TOC_ADDR_PER_SH: rd_mux[`TOC_CW-1:0] = period_shadow_q;
      `TOC_ADDR_DUTY_SH: rd_mux[`TOC_CW-1:0] = duty_shadow_q;
      `TOC_ADDR_IRQ_STAT: rd_mux[`TOC_IRQ_W-1:0] = interrupt_notification_bits_q;
      `TOC_ADDR_IRQ_CLR: rd_mux = 32'h00000000;
      `TOC_ADDR_IRQ_EN: rd_mux[`TOC_IRQ_W-1:0] = irq_en_q;
      `TOC_ADDR_STATUS: rd_mux[3:0] = {phase_q, active_q, channel_out};
      default: addr_ok = 1'b0;
    endcase
  end

  // One wait state keeps ready and read data registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_prep;
      pslverr <= apb_prep & ~addr_ok;
      if (apb_prep & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

/* toc_channel_monitor.sv */
// Port-level timing checks for the timer output channel
`timescale 1ns/1ps
`default_nettype none
module toc_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Channel
  input wire logic period_match_trigger,
  input wire logic duty_match_trigger,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  AST_BUS_WAIT: assert property (s_setup |=> s_one_wait)
    else $error("ready not after one wait state");
  AST_READY_QUAL: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_SETUP_QUIET: assert property (s_setup |-> !pready && !pslverr)
    else $error("answer during setup");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_RDATA_HOLD: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
  // Status lands a cycle after the trigger, the line one more
  AST_IRQ_RISE: assert property ($rose(irq) |->
    $past(period_match_trigger, 2) || $past(duty_match_trigger, 2))
    else $error("interrupt without a compare trigger");
  // Only a register write may drop a raised interrupt
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(pready && pwrite, 2))
    else $error("interrupt dropped without a write");
endmodule
bind toc_channel toc_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .period_match_trigger(period_match_trigger),
  .duty_match_trigger(duty_match_trigger), .irq(irq));
`default_nettype wire

/* toc_actuator.sv */
// Actuator model on the channel pin: drive time and edge spacing
`timescale 1ns/1ps
`default_nettype none
module toc_actuator (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Driven pin
  input wire logic pin,
  // Observations
  output logic [15:0] on_cycles,
  output logic [15:0] rises,
  output logic [15:0] gap
);
  logic pin_q;
  logic [15:0] since;
  // Load sees only the level held at each edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
      on_cycles <= 16'h0000;
      rises <= 16'h0000;
      gap <= 16'h0000;
      since <= 16'h0000;
    end else begin
      pin_q <= pin;
      since <= since + 16'h0001;
      if (pin)
        on_cycles <= on_cycles + 16'h0001;
      if (pin && !pin_q) begin
        rises <= rises + 16'h0001;
        gap <= since + 16'h0001;
        since <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

/* timer_output_channel_oneshot_test.sv */
// Self-checking bench for the timer output channel
`timescale 1ns/1ps
`default_nettype none
`include "toc_defines.vh"
module timer_output_channel_oneshot_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic chain = 1'b0;
  logic cap = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, ch_out, pt, dt, irq;
  wire [15:0] on_c, rises, gap;
  logic [31:0] rd;
  logic err;
  logic [15:0] s0;
  int n_errors = 0;
  int check_count = 0;
  int pt_n, dt_n, pt_base, dt_base, n, off;
  int per [3] = '{6, 5, 4};
  int dut [3] = '{3, 1, 2};
  toc_channel i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chain_trigger_in(chain), .external_capture_event(cap),
    .channel_out(ch_out), .period_match_trigger(pt), .duty_match_trigger(dt), .irq(irq));
  toc_actuator i_act (.pclk(pclk), .presetn(presetn), .pin(ch_out), .on_cycles(on_c),
    .rises(rises), .gap(gap));
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    if (pt === 1'b1)
      pt_n <= pt_n + 1;
    if (dt === 1'b1)
      dt_n <= dt_n + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until ready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
      n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_pt(input int k, output int c);
    c = 0;
    while (pt_n - pt_base < k && c < 2000) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 2000)
      n_errors++;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #3000000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    check(ch_out, 0);
    apb(1, 8'h40, 32'h3);
    check(err, 1);
    apb(0, `TOC_ADDR_IRQ_STAT, 0);
    check(rd, 0);
    apb(1, `TOC_ADDR_IRQ_EN, 3);
    // Rows: chain start, duty of one, capture start
    for (int i = 0; i < 3; i++) begin
      apb(1, `TOC_ADDR_PER, per[i]);
      apb(1, `TOC_ADDR_DUTY, dut[i]);
      apb(1, `TOC_ADDR_CTRL, i == 2 ? 32'h40d : 32'h405);
      pt_base = pt_n;
      dt_base = dt_n;
      s0 = on_c;
      if (i == 2)
        cap <= 1'b1;
      else
        chain <= 1'b1;
      @(posedge pclk);
      chain <= 1'b0;
      wait_pt(1, n);
      if (i == 0)
        off = n - per[0];
      if (i == 1)
        check(n - per[1], off);
      wait_pt(2, n);
      check(n, per[i]);
      repeat (4) @(posedge pclk);
      cap <= 1'b0;
      check(on_c - s0, dut[i]);
      check(dt_n - dt_base, 2);
    end
    // Counter write start, last one at period minus one
    for (int j = 0; j < 2; j++) begin
      pt_base = pt_n;
      apb(1, `TOC_ADDR_CNT, 3 * j);
      wait_pt(1, n);
      if (j == 0)
        off = n;
      else
        check(off - n, 3);
      wait_pt(2, n);
    end
    apb(0, `TOC_ADDR_IRQ_STAT, 0);
    check(rd, 3);
    check(irq, 1);
    apb(1, `TOC_ADDR_IRQ_EN, 0);
    apb(0, `TOC_ADDR_IRQ_STAT, 0);
    check(rd, 3);
    check(irq, 0);
    apb(1, `TOC_ADDR_IRQ_CLR, 3);
    apb(0, `TOC_ADDR_IRQ_STAT, 0);
    check(rd, 0);
    // Divided enable every fourth clock
    apb(1, `TOC_ADDR_PER, 32'h100);
    apb(1, `TOC_ADDR_DIV, 3);
    apb(1, `TOC_ADDR_CTRL, 32'h401);
    apb(0, `TOC_ADDR_CNT, 0);
    off = rd;
    repeat (36) @(posedge pclk);
    apb(0, `TOC_ADDR_CNT, 0);
    check(rd - off, 10);
    // Near-frozen enable: capture must wait for a tick
    apb(1, `TOC_ADDR_DIV, 32'hffff);
    apb(1, `TOC_ADDR_CTRL, 32'h419);
    apb(1, `TOC_ADDR_CNT, 32'h80);
    cap <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(0, `TOC_ADDR_CNT, 0);
    check(rd, 32'h80);
    apb(1, `TOC_ADDR_DIV, 0);
    apb(0, `TOC_ADDR_CNT, 0);
    check(rd < 32'h10, 1);
    apb(1, `TOC_ADDR_CTRL, 32'h409);
    apb(1, `TOC_ADDR_CNT, 32'h80);
    cap <= 1'b0;
    repeat (2) @(posedge pclk);
    cap <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(0, `TOC_ADDR_CNT, 0);
    check(rd >= 32'h80, 1);
    // Longest shift, no reload: one set bit every 24 clocks
    apb(1, `TOC_ADDR_PER, `TOC_SHIFT_MAX);
    apb(1, `TOC_ADDR_DUTY, 1);
    apb(1, `TOC_ADDR_CTRL, 32'h403);
    s0 = rises;
    n = 0;
    while (rises - s0 < 3 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    check(gap, 24);
    final_report();
  end
endmodule
`default_nettype wire
